// [design/pcr_pkg.sv]
/*
  Package for the port pad configuration bank: register map, write masks,
  reset value, field positions, pad codes and the carrier structs.
  Assumes a 16-bit special-function-register address and data path.
*/
package pcr_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int          REG_COUNT   = 17;
  localparam logic [4:0]  IDX_NONE    = 5'h11;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [15:0] EXTENDED_SFR_SPACE_FIRST  = 16'hF000;
  localparam logic [15:0] EXTENDED_SFR_SPACE_LAST   = 16'hF1FF;

  localparam int IDX_DRV_P0L = 0;
  localparam int IDX_DRV_P0H = 1;
  localparam int IDX_DRV_P1L = 2;
  localparam int IDX_DRV_P1H = 3;
  localparam int IDX_DRV_P2  = 4;
  localparam int IDX_DRV_P3  = 5;
  localparam int IDX_DRV_P4  = 6;
  localparam int IDX_DRV_P6  = 7;
  localparam int IDX_DRV_P7  = 8;
  localparam int IDX_DRV_P8  = 9;
  localparam int IDX_THR     = 10;
  localparam int IDX_OD_P2   = 11;
  localparam int IDX_OD_P3   = 12;
  localparam int IDX_OD_P4   = 13;
  localparam int IDX_OD_P6   = 14;
  localparam int IDX_OD_P7   = 15;
  localparam int IDX_OD_P8   = 16;

  localparam logic [15:0] REG_ADDR [REG_COUNT] = '{
    16'hF080, 16'hF082, 16'hF084, 16'hF086, 16'hF088, 16'hF08A,
    16'hF08C, 16'hF08E, 16'hF090, 16'hF092, 16'hF1C4,
    16'hF1E0, 16'hF1E2, 16'hF1E4, 16'hF1E6, 16'hF1E8, 16'hF1EA};

  // bits outside a mask are not stored and read as zero
  localparam logic [15:0] MASK_BYTE = 16'h00FF;
  localparam logic [15:0] MASK_WORD = 16'hFFFF;
  localparam logic [15:0] MASK_THR  = 16'h00DF;

  localparam logic [15:0] REG_MASK [REG_COUNT] = '{
    MASK_BYTE, MASK_BYTE, MASK_BYTE, MASK_BYTE, MASK_WORD, MASK_WORD,
    MASK_BYTE, MASK_BYTE, MASK_BYTE, MASK_BYTE, MASK_THR,
    MASK_WORD, MASK_WORD, MASK_BYTE, MASK_BYTE, MASK_BYTE, MASK_BYTE};

  // ----------------------------------------------------------------------
  // threshold field positions
  // ----------------------------------------------------------------------
  localparam int THR_P2_LOW  = 0;
  localparam int THR_P2_HIGH = 1;
  localparam int THR_P3_LOW  = 2;
  localparam int THR_P3_HIGH = 3;
  localparam int THR_P4_LOW  = 4;
  localparam int THR_P7_LOW  = 6;
  localparam int THR_P8_LOW  = 7;

  // ----------------------------------------------------------------------
  // pad codes, as the pad ring interprets them
  // ----------------------------------------------------------------------
  localparam logic [1:0] EDGE_FAST   = 2'h0;
  localparam logic [1:0] EDGE_SLOW   = 2'h1;
  localparam logic [1:0] DRV_FULL    = 2'h0;
  localparam logic [1:0] DRV_DYNAMIC = 2'h1;
  localparam logic [1:0] DRV_LOW     = 2'h2;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] drive;
    logic [1:0] edge_rate;
  } pcr_nib_type;

  typedef pcr_nib_type [3:0] pcr_nibs_type;

  typedef struct packed {
    pcr_nibs_type p8;
    pcr_nibs_type p7;
    pcr_nibs_type p6;
    pcr_nibs_type p4;
    pcr_nibs_type p3;
    pcr_nibs_type p2;
    pcr_nibs_type p1h;
    pcr_nibs_type p1l;
    pcr_nibs_type p0h;
    pcr_nibs_type p0l;
  } pcr_drv_type;

  typedef struct packed {
    logic [7:0]  p8;
    logic [7:0]  p7;
    logic [7:0]  p6;
    logic [7:0]  p4;
    logic [15:0] p3;
    logic [15:0] p2;
  } pcr_od_type;

  typedef struct packed {
    logic p8_low;
    logic p7_low;
    logic p4_low;
    logic p3_high;
    logic p3_low;
    logic p2_high;
    logic p2_low;
  } pcr_thr_type;

endpackage : pcr_pkg

// [design/pcr_cfg_word.sv]
/*
  One stored configuration word: takes the masked write data on a write
  strobe and holds it. Assumes the caller decodes the address.
*/
`timescale 1ns/1ns
module pcr_cfg_word
  import pcr_pkg::*;
#(
  parameter logic [15:0] MASK = MASK_WORD
) (
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  input  wire logic        wr_en_in,
  input  wire logic [15:0] data_in,
  output logic      [15:0] q_out
);

  logic [15:0] word_reg;

  // unstored bits stay zero, so reads need no further masking
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      word_reg <= RST_WORD;
    end else if (wr_en_in) begin
      word_reg <= data_in & MASK;
    end
  end

  assign q_out = word_reg;

endmodule : pcr_cfg_word

// [design/pcr_pad_config.sv]
/*
  Pad configuration bank for the parallel ports: open-drain selection per
  line, input threshold per port byte, edge rate and drive per nibble.
  Assumes a synchronous single-cycle register port from the CPU side and
  a pad ring that samples the static control lines at any time.
*/
// Design decision made here: the strobed register port.
// Notes on behaviour
// - open-drain bit: 0 push-pull, 1 open-drain
// - per-line open-drain for ports 2,3,4,6,7,8
// - open-drain registers live in extended space
// - threshold chosen per port byte
// - fixed threshold bit layout, bit 5 unused
// - threshold 0 TTL, 1 hysteresis levels
// - threshold never affects direction or output mode
// - edge field: 00 fast, 01 slow
// - drive field: 00 full, 01 dynamic, 10 low
// - one edge/drive pair per four-pin nibble
// - byte-port drive registers read 00h high byte
// - word-port drive registers hold four nibble pairs
// - port 3 top nibble drives pins 15,13,12
`timescale 1ns/1ns
module pcr_pad_config
  import pcr_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  output pcr_od_type       od_out,
  output pcr_thr_type      thr_out,
  output pcr_drv_type      drv_out
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic [4:0] reg_index(input logic [15:0] a);
    logic [4:0] r;
    r = IDX_NONE;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (a == REG_ADDR[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : reg_index

  logic [4:0]  wr_idx;
  logic [4:0]  rd_idx;
  logic [15:0] word_q [REG_COUNT];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  assign wr_idx = reg_index(addr_in);
  assign rd_idx = reg_index(addr_in);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // every word sits in the extended space and resets to zero, so all
  // lines come up push-pull, TTL, fast edge and full strength
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_word
    pcr_cfg_word #(
      .MASK (REG_MASK[g])
    ) u_word (
      .clock_in  (clock_in),
      .arst_n_in (arst_n_in),
      .wr_en_in  (wr_in && (wr_idx == 5'(g))),
      .data_in   (wdata_in),
      .q_out     (word_q[g])
    );
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  // masked storage already yields zero in unused and high-byte bits
  always_comb begin
    rdata_next = RST_WORD;
    if (rd_in && (rd_idx != IDX_NONE)) begin
      rdata_next = word_q[rd_idx];
    end
  end

  // data stand one cycle only; an unmapped read answers zero
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg <= RST_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

  // ----------------------------------------------------------------------
  // open-drain lines
  // ----------------------------------------------------------------------
  // one bit per line; a 1 turns the line's driver open-drain
  assign od_out.p2 = word_q[IDX_OD_P2];
  assign od_out.p3 = word_q[IDX_OD_P3];
  assign od_out.p4 = word_q[IDX_OD_P4][7:0];
  assign od_out.p6 = word_q[IDX_OD_P6][7:0];
  assign od_out.p7 = word_q[IDX_OD_P7][7:0];
  assign od_out.p8 = word_q[IDX_OD_P8][7:0];

  // ----------------------------------------------------------------------
  // input thresholds
  // ----------------------------------------------------------------------
  // a 1 selects the hysteresis levels for the byte's eight pins; nothing
  // here gates the open-drain or drive lines, so those stay independent
  assign thr_out.p2_low  = word_q[IDX_THR][THR_P2_LOW];
  assign thr_out.p2_high = word_q[IDX_THR][THR_P2_HIGH];
  assign thr_out.p3_low  = word_q[IDX_THR][THR_P3_LOW];
  assign thr_out.p3_high = word_q[IDX_THR][THR_P3_HIGH];
  assign thr_out.p4_low  = word_q[IDX_THR][THR_P4_LOW];
  assign thr_out.p7_low  = word_q[IDX_THR][THR_P7_LOW];
  assign thr_out.p8_low  = word_q[IDX_THR][THR_P8_LOW];

  // ----------------------------------------------------------------------
  // output drive nibbles
  // ----------------------------------------------------------------------
  // each nibble holds edge rate in its low pair and drive in its high
  // pair; codes pass to the pads unchanged, reserved ones included, since
  // the pad ring owns their meaning
  assign drv_out.p0l = pcr_nibs_type'(word_q[IDX_DRV_P0L]);
  assign drv_out.p0h = pcr_nibs_type'(word_q[IDX_DRV_P0H]);
  assign drv_out.p1l = pcr_nibs_type'(word_q[IDX_DRV_P1L]);
  assign drv_out.p1h = pcr_nibs_type'(word_q[IDX_DRV_P1H]);
  assign drv_out.p2  = pcr_nibs_type'(word_q[IDX_DRV_P2]);
  // nibble 3 of port 3 reaches pins 15, 13 and 12; pin 14 has no pad
  assign drv_out.p3  = pcr_nibs_type'(word_q[IDX_DRV_P3]);
  assign drv_out.p4  = pcr_nibs_type'(word_q[IDX_DRV_P4]);
  assign drv_out.p6  = pcr_nibs_type'(word_q[IDX_DRV_P6]);
  assign drv_out.p7  = pcr_nibs_type'(word_q[IDX_DRV_P7]);
  assign drv_out.p8  = pcr_nibs_type'(word_q[IDX_DRV_P8]);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_od_write_lands: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_OD_P2])
    |=> od_out.p2 == $past(wdata_in)
  ) else $error("open-drain write did not reach port 2 lines");

  a_od_byte_port: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_OD_P6])
    ##1 rd_in && (addr_in == REG_ADDR[IDX_OD_P6])
    |=> rdata_out == {8'h00, $past(wdata_in[7:0], 2)}
  ) else $error("port 6 open-drain readback wrong");

  a_outside_ext_space: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && ((addr_in < EXTENDED_SFR_SPACE_FIRST) || (addr_in > EXTENDED_SFR_SPACE_LAST))
    |=> $stable(od_out) && $stable(thr_out) && $stable(drv_out)
  ) else $error("write outside extended space changed a pad line");

  a_thr_layout: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_THR])
    |=> thr_out.p2_high == $past(wdata_in[1])
        && thr_out.p4_low == $past(wdata_in[4])
        && thr_out.p7_low == $past(wdata_in[6])
        && thr_out.p8_low == $past(wdata_in[7])
  ) else $error("threshold bit layout wrong");

  a_thr_unused_zero: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    rd_in && (addr_in == REG_ADDR[IDX_THR])
    |=> rdata_out[15:8] == 8'h00 && rdata_out[5] == 1'b0
  ) else $error("unused threshold bits read nonzero");

  a_thr_independent: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_THR])
    |=> $stable(od_out) && $stable(drv_out)
  ) else $error("threshold write disturbed output mode");

  a_byte_high_zero: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P4])
    ##1 rd_in && (addr_in == REG_ADDR[IDX_DRV_P4])
    |=> rdata_out == {8'h00, $past(wdata_in[7:0], 2)}
  ) else $error("byte drive register readback wrong");

  a_word_nibbles: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P3])
    |=> drv_out.p3[3].drive == $past(wdata_in[15:14])
        && drv_out.p3[3].edge_rate == $past(wdata_in[13:12])
        && drv_out.p3[0].edge_rate == $past(wdata_in[1:0])
  ) else $error("word drive nibble layout wrong");

  a_hold_no_write: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    !wr_in [*2]
    |-> $stable(od_out) && $stable(thr_out) && $stable(drv_out)
  ) else $error("pad lines changed without a write");

  a_read_one_cycle: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    !rd_in |=> rdata_out == RST_WORD
  ) else $error("read data stood beyond its cycle");

  a_reset_defaults: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    $rose(arst_n_in)
    |-> od_out == '0 && thr_out == '0 && drv_out == '0
  ) else $error("pad lines not at defaults after reset");

  a_od_p3_lines: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_OD_P3])
    |=> od_out.p3 == $past(wdata_in)
  ) else $error("open-drain write did not reach port 3 lines");

  a_od_p4_lines: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_OD_P4])
    |=> od_out.p4 == $past(wdata_in[7:0])
  ) else $error("open-drain write did not reach port 4 lines");

  a_od_p6_lines: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_OD_P6])
    |=> od_out.p6 == $past(wdata_in[7:0])
  ) else $error("open-drain write did not reach port 6 lines");

  a_od_p7_lines: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_OD_P7])
    |=> od_out.p7 == $past(wdata_in[7:0])
  ) else $error("open-drain write did not reach port 7 lines");

  a_od_p8_lines: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_OD_P8])
    |=> od_out.p8 == $past(wdata_in[7:0])
  ) else $error("open-drain write did not reach port 8 lines");

  a_thr_low_bytes: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_THR])
    |=> thr_out.p2_low == $past(wdata_in[0])
        && thr_out.p3_low == $past(wdata_in[2])
        && thr_out.p3_high == $past(wdata_in[3])
  ) else $error("threshold byte selection wrong");

  a_thr_hyst_select: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_THR])
    |=> thr_out == {$past(wdata_in[7:6]), $past(wdata_in[4:0])}
  ) else $error("threshold level selection wrong");

  a_thr_keeps_mode: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in != REG_ADDR[IDX_THR])
    |=> $stable(thr_out)
  ) else $error("mode write disturbed a threshold line");

  a_edge_rate_field: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P7])
    |=> drv_out.p7[0].edge_rate == $past(wdata_in[1:0])
        && drv_out.p7[1].edge_rate == $past(wdata_in[5:4])
  ) else $error("edge rate field placement wrong");

  a_drive_field: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P8])
    |=> drv_out.p8[0].drive == $past(wdata_in[3:2])
        && drv_out.p8[1].drive == $past(wdata_in[7:6])
  ) else $error("drive field placement wrong");

  a_nibble_p0_low: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P0L])
    |=> drv_out.p0l[1:0] == $past(wdata_in[7:0])
  ) else $error("port 0 low nibble pairs wrong");

  a_nibble_p0_high: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P0H])
    |=> drv_out.p0h[1:0] == $past(wdata_in[7:0])
  ) else $error("port 0 high nibble pairs wrong");

  a_nibble_p1_low: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P1L])
    |=> drv_out.p1l[1:0] == $past(wdata_in[7:0])
  ) else $error("port 1 low nibble pairs wrong");

  a_nibble_p1_high: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P1H])
    |=> drv_out.p1h[1:0] == $past(wdata_in[7:0])
  ) else $error("port 1 high nibble pairs wrong");

  a_byte_upper_zero: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in
    |=> drv_out.p4[3:2] == '0 && drv_out.p6[3:2] == '0
        && drv_out.p7[3:2] == '0 && drv_out.p8[3:2] == '0
  ) else $error("byte port upper nibbles not zero");

  a_word_p2_nibbles: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P2])
    |=> drv_out.p2 == $past(wdata_in)
  ) else $error("port 2 nibble pairs wrong");

  a_p3_top_nibble: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in && (addr_in == REG_ADDR[IDX_DRV_P3])
    |=> drv_out.p3[3] == $past(wdata_in[15:12])
  ) else $error("port 3 top nibble wrong");

  a_read_returns: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    rd_in && (addr_in == REG_ADDR[IDX_DRV_P2])
    |=> rdata_out == drv_out.p2
  ) else $error("read data differ from stored drive word");

  a_unmapped_read: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    rd_in && (reg_index(addr_in) == IDX_NONE)
    |=> rdata_out == RST_WORD
  ) else $error("unmapped read returned nonzero data");

  a_write_no_data: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    wr_in |=> rdata_out == RST_WORD
  ) else $error("write cycle produced read data");

  a_od_readback: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    rd_in && (addr_in == REG_ADDR[IDX_OD_P2])
    |=> rdata_out == od_out.p2
  ) else $error("open-drain readback differs from lines");

  a_thr_readback: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    rd_in && (addr_in == REG_ADDR[IDX_THR])
    |=> rdata_out == {8'h00, thr_out[6:5], 1'b0, thr_out[4:0]}
  ) else $error("threshold readback differs from lines");

endmodule : pcr_pad_config

// [sim/tb_top.sv]
/*
  Self-checking bench for the pad configuration bank: register writes and
  reads over the strobe port, pad outputs watched against a model.
  Assumes the bank answers reads one cycle late and never stalls.
*/
`timescale 1ns/1ns
module tb_top;
  import pcr_pkg::*;

  typedef struct {
    int          kind;
    int          idx;
    logic [15:0] exp;
  } pcr_note_type;

  logic        clock_in;
  logic        arst_n_in;
  logic [15:0] addr_in;
  logic [15:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [15:0] rdata_out;
  pcr_od_type  od_out;
  pcr_thr_type thr_out;
  pcr_drv_type drv_out;
  logic        pend_reg;
  logic [15:0] mdl [REG_COUNT];
  logic [15:0] shd [REG_COUNT];
  logic [31:0] seed;
  logic [31:0] r;
  pcr_note_type notes [$];
  pcr_note_type nt;
  int          fail_count;
  int          checks_done;
  int          cycles;

  pcr_pad_config i_dut (
    .clock_in (clock_in), .arst_n_in (arst_n_in), .addr_in (addr_in),
    .wdata_in (wdata_in), .wr_in (wr_in), .rd_in (rd_in),
    .rdata_out (rdata_out), .od_out (od_out), .thr_out (thr_out),
    .drv_out (drv_out));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  function automatic int idx_of(input logic [15:0] a);
    for (int i = 0; i < REG_COUNT; i++)
      if (REG_ADDR[i] === a) return i;
    return -1;
  endfunction : idx_of

  // pad lines gathered back into the layout of their register
  function automatic logic [15:0] pad_word(input int i);
    logic [159:0] d;
    logic [63:0]  o;
    d = drv_out;
    o = od_out;
    if (i < 10) return d[16*i +: 16];
    if (i == 10) return {8'h00, thr_out[6:5], 1'b0, thr_out[4:0]};
    if (i == 11) return o[15:0];
    if (i == 12) return o[31:16];
    return {8'h00, o[32 + 8*(i-13) +: 8]};
  endfunction : pad_word

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic wr_op(input logic [15:0] a, input logic [15:0] d);
    int i;
    i = idx_of(a);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    rd_in    <= 1'b0;
    if (i >= 0) begin
      mdl[i] = d & REG_MASK[i];
      notes.push_back('{1, i, mdl[i]});
    end else notes.push_back('{2, 0, 16'h0000});
  endtask : wr_op

  task automatic rd_op(input logic [15:0] a);
    int i;
    i = idx_of(a);
    @(posedge clock_in);
    addr_in <= a;
    wr_in   <= 1'b0;
    rd_in   <= 1'b1;
    notes.push_back('{0, 0, (i >= 0) ? mdl[i] : 16'h0000});
  endtask : rd_op

  task automatic settle;
    @(posedge clock_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    @(negedge clock_in);
  endtask : settle

  // ----------------------------------------------------------------------
  // clock, monitor, timeout
  // ----------------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) pend_reg <= 1'b0;
    else pend_reg <= wr_in | rd_in;
  end

  // results settle by mid-cycle, so the oldest note is judged there
  // shadow of landed writes, so an ignored write can be judged on all pads
  always @(negedge clock_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < REG_COUNT; i++) shd[i] = 16'h0000;
    end else if (pend_reg && notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt.kind)
        0: check(rdata_out, nt.exp);
        1: begin
          check(pad_word(nt.idx), nt.exp);
          shd[nt.idx] = nt.exp;
        end
        default: begin
          check(rdata_out, 16'h0000);
          for (int i = 0; i < REG_COUNT; i++) begin
            check(pad_word(i), shd[i]);
          end
        end
      endcase
    end
  end

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    seed = 32'hD7CF;
    arst_n_in = 1'b0;
    addr_in = 16'h0000;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    for (int i = 0; i < REG_COUNT; i++) mdl[i] = 16'h0000;
    repeat (10) @(posedge clock_in);
    arst_n_in <= 1'b1;
    check(od_out[15:0] | od_out[63:48], 16'h0000);
    for (int i = 0; i < REG_COUNT; i++) rd_op(REG_ADDR[i]);
    settle();
    for (int b = 0; b < 16; b++) begin
      wr_op(REG_ADDR[IDX_OD_P3], 16'h0001 << b);
      settle();
      check(od_out.p3, 16'h0001 << b);
    end
    wr_op(16'hFFE2, 16'hFFFF);
    rd_op(16'hFFE2);
    wr_op(REG_ADDR[IDX_THR], 16'hFFFF);
    rd_op(REG_ADDR[IDX_THR]);
    settle();
    check({9'h000, thr_out}, 16'h007F);
    wr_op(REG_ADDR[IDX_THR], 16'h0001 << THR_P4_LOW);
    settle();
    check({15'h0000, thr_out.p4_low}, 16'h0001);
    check({9'h000, thr_out}, 16'h0010);
    check(od_out.p3, 16'h8000);
    for (int n = 0; n < 4; n++) begin
      for (int c = 0; c < 16; c++) begin
        wr_op(REG_ADDR[IDX_DRV_P3], c[15:0] << (4 * n));
        settle();
        check({14'h0000, drv_out.p3[n].edge_rate}, c & 3);
        check({14'h0000, drv_out.p3[n].drive}, c >> 2);
        check(drv_out.p3[(n + 1) % 4], 16'h0000);
      end
    end
    wr_op(REG_ADDR[IDX_DRV_P3], 16'hB000);
    settle();
    check({12'h000, drv_out.p3[3]}, 16'h000B);
    wr_op(REG_ADDR[IDX_DRV_P4], 16'hFFFF);
    rd_op(REG_ADDR[IDX_DRV_P4]);
    wr_op(REG_ADDR[IDX_DRV_P2], 16'hA5C3);
    rd_op(REG_ADDR[IDX_DRV_P2]);
    settle();
    check(drv_out.p2, 16'hA5C3);
    // back-to-back random traffic, unmapped addresses mixed in
    for (int k = 0; k < 400; k++) begin
      seed = xs(seed);
      r = seed;
      seed = xs(seed);
      if (r[6]) wr_op(r[5] ? REG_ADDR[r[4:0] % 17] : {r[31:17], 1'b0},
                      seed[15:0]);
      else rd_op(r[5] ? REG_ADDR[r[4:0] % 17] : {r[31:17], 1'b0});
    end
    settle();
    // reset in mid-run must bring every word back to zero
    @(posedge clock_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < REG_COUNT; i++) mdl[i] = 16'h0000;
    for (int i = 0; i < REG_COUNT; i++) rd_op(REG_ADDR[i]);
    settle();
    check(pad_word(IDX_DRV_P3), 16'h0000);
    end_of_test();
  end
endmodule : tb_top
